// >>> inc/apr_pkg.sv
// Purpose: Shared constants and types for the audio path block
// Assumes: APB data 32 bits, samples 24 bits
// Notes:   Register map and field layout live here
package apr_pkg;
  localparam int SW     = 24;
  localparam int DW     = 48;
  localparam int NBQ    = 10;
  localparam int NDP    = 2;
  localparam int NTAP   = 5;
  localparam int NCOEF  = NBQ * NTAP;
  localparam int CFRAC  = 22;
  localparam logic [23:0] COEF_ONE = 24'h400000;
  localparam logic [11:0] A_CTRL = 12'h000;
  localparam logic [11:0] A_GAIN = 12'h004;
  localparam logic [11:0] A_BATT = 12'h008;
  localparam logic [11:0] A_STAT = 12'h00C;
  localparam logic [11:0] A_PART = 12'h010;
  localparam logic [11:0] A_COEF = 12'h100;
  localparam logic [11:0] CSPAN  = 12'(4 * NCOEF);
  localparam int CTRL_W = 10;
  localparam int C_PDM = 0;
  localparam int C_INPUT_STREAM_SELECT = 1;
  localparam int C_PASS = 2;
  localparam int C_PSRC = 3;
  localparam int C_OSRC = 4;
  localparam int C_AEC = 7;
  localparam int C_STEREO = 8;
  localparam int C_BWE = 9;
  localparam int OSRC_W = 3;
  localparam logic [OSRC_W-1:0] OSRC_DSP = 3'h0;
  localparam logic [OSRC_W-1:0] OSRC_CUR = 3'h1;
  localparam logic [OSRC_W-1:0] OSRC_LEFT = 3'h2;
  localparam logic [OSRC_W-1:0] OSRC_RIGHT = 3'h3;
  localparam logic [OSRC_W-1:0] OSRC_GAIN = 3'h4;
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
  localparam logic [7:0] GAIN_RST = 8'h80;
  localparam logic [7:0] THR_RST = 8'h40;
  localparam logic [3:0] RED_RST = 4'h1;
  localparam int RS_LSB = 8;
  localparam int RS_W = 4;
  localparam int UNITY_SH = 7;
  localparam logic [7:0] BWE_LIMIT = 8'h10;
  localparam logic [5:0] PDM_DEC_LAST = 6'h3F;
  localparam logic [23:0] PDM_MID = 24'h200000;
  localparam logic [4:0] WSM_LAST = 5'h1F;
  localparam logic [25:0] SD_FS = 26'h0800000;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_MAC   = 3'b010,
    ST_STORE = 3'b100
  } apr_st_t;
endpackage

// >>> hdl/apr_audio_path.sv
// Purpose: Audio input routing, biquad chain, gain and PWM drive
// Assumes: battery_level and amp_current come from logic on pclk
// Notes:   Serial pins are oversampled on link_clk
// Function
// R01: In serial mode the audio stream comes from the first or second input per the select bit.
// R02: The stereo link input is sampled with the selected frame and bit clock pair.
// R03: With pass-through on, a chosen serial input drives the serial output directly.
// R04: Density mode takes audio from the density input and emits an echo reference stream.
// R05: Density mode reserves the link input and serial output for gain exchange.
// R06: The serial output carries one chosen source: processor, current, link left/right or gain.
// R07: Audio passes cascaded biquads, the first two at 48 bits, the rest at 24 bits.
// R08: Low battery reduces the audio gain automatically.
// R09: A host controlling volume itself must switch off the automatic boost features.
// R10: Processed audio becomes two PWM drive signals in a three-level scheme.
// R11: Boost control follows the battery when demand is below it and boosts only as needed.
// R12: Bandwidth extension raises bass extension to a limit before raising the level.
// R13: The echo reference pin is undriven in serial mode or mono density mode.
// R14: Density mode drives a master frame select output for partner gain exchange.
// R15: One setting chooses serial or density mode and all routing follows it.
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module apr_audio_path (
  input  wire logic        pclk,                    // Bus clock
  input  wire logic        presetn,                 // Async reset, low
  input  wire logic        link_clk,                // Pin sampling clock
  input  wire logic [11:0] paddr,                   // APB address
  input  wire logic        psel,                    // APB select
  input  wire logic        penable,                 // APB enable
  input  wire logic        pwrite,                  // APB write
  input  wire logic [31:0] pwdata,                  // APB write data
  output logic      [31:0] prdata,                  // APB read data
  output logic             pready,                  // APB ready
  output logic             pslverr,                 // APB error
  input  wire logic        serial_bit_clock_first,  // Bit clock 1
  input  wire logic        frame_select_first,      // Word select 1
  input  wire logic        serial_audio_in_first,   // Data 1
  input  wire logic        serial_bit_clock_second, // Bit clock 2
  input  wire logic        frame_select_second,     // Word select 2
  input  wire logic        serial_audio_in_second,  // Data 2
  input  wire logic        stereo_link_in,          // Link data
  input  wire logic        density_clock_in,        // Density clock
  input  wire logic        density_data_in,         // Density data
  output logic             serial_audio_out,        // Serial out
  output logic             echo_reference_out,      // Echo stream
  output logic             echo_reference_oe,       // Echo drive enable
  output logic             master_frame_select_out, // Master word select
  output logic             master_frame_select_oe,  // Its drive enable
  input  wire logic [7:0]  battery_level,           // Battery code
  input  wire logic [23:0] amp_current,             // Current sense
  output logic             pwm_pos,                 // Drive A
  output logic             pwm_neg,                 // Drive B
  output logic      [7:0]  boost_demand,            // Boost level
  output logic             follower_mode,           // No boost
  output logic      [7:0]  bass_extension           // Bass ext level
);
  function automatic logic [5:0] ci(input logic [3:0] s, input logic [2:0] t);
    return 6'(int'(s) * apr_pkg::NTAP + int'(t));
  endfunction
  function automatic logic signed [47:0] prec(input logic [3:0] s, input logic [47:0] v);
    return (int'(s) < apr_pkg::NDP) ? v : {v[47:24], 24'h0};
  endfunction
  function automatic logic [23:0] sat(input logic signed [31:0] v);
    return (v > 32'sh7FFFFF) ? 24'h7FFFFF : (v < -32'sh800000) ? 24'h800000 : v[23:0];
  endfunction

  // ---------------- Bus domain ----------------
  logic [apr_pkg::CTRL_W-1:0] ctrl_reg;
  logic [7:0]  gain_t_reg, thr_reg, gain_reg, bass_reg;
  logic [3:0]  red_reg;
  logic [23:0] part_reg, out_reg, ow_reg, aw_reg;
  logic        rdy_reg, err_reg, otg_reg;
  logic [31:0] rdata_reg;
  logic [23:0] coef_mem [apr_pkg::NCOEF];
  logic [47:0] bundle_reg;
  logic [2:0]  rtg_sync;

  wire acc_ph = psel & penable;
  wire first  = acc_ph & ~rdy_reg;
  wire wr     = acc_ph & rdy_reg & pwrite;
  wire h_ctrl = paddr == apr_pkg::A_CTRL;
  wire h_gain = paddr == apr_pkg::A_GAIN;
  wire h_batt = paddr == apr_pkg::A_BATT;
  wire h_stat = paddr == apr_pkg::A_STAT;
  wire h_part = paddr == apr_pkg::A_PART;
  wire [11:0] coff = paddr - apr_pkg::A_COEF;
  wire h_coef = (paddr >= apr_pkg::A_COEF) && (coff < apr_pkg::CSPAN) && (paddr[1:0] == 2'h0);
  wire [5:0]  widx = coff[7:2];
  wire hit = h_ctrl | h_gain | h_batt | h_stat | h_part | h_coef;
  wire batt_low = battery_level < thr_reg;
  wire busy;
  wire [31:0] stat_w = {8'h00, bass_reg, gain_reg, 5'h00, busy, follower_mode, batt_low};
  wire [31:0] rmux = h_ctrl ? 32'(ctrl_reg) : h_gain ? {24'h0, gain_t_reg} :
                     h_batt ? {20'h0, red_reg, thr_reg} : h_stat ? stat_w :
                     h_part ? {8'h00, part_reg} : h_coef ? {8'h00, coef_mem[widx]} : 32'h0;
  assign pready  = rdy_reg;
  assign prdata  = rdata_reg;
  assign pslverr = rdy_reg & err_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_reg <= 1'b0;
      err_reg <= 1'b0;
      rdata_reg <= 32'h0;
      ctrl_reg <= apr_pkg::CTRL_RST;
      gain_t_reg <= apr_pkg::GAIN_RST;
      thr_reg <= apr_pkg::THR_RST;
      red_reg <= apr_pkg::RED_RST;
    end else begin
      rdy_reg <= first;
      if (first) begin
        rdata_reg <= rmux;
        err_reg <= ~hit;
      end
      if (wr && h_ctrl) ctrl_reg <= pwdata[apr_pkg::CTRL_W-1:0]; // R15
      if (wr && h_gain) gain_t_reg <= pwdata[7:0];
      if (wr && h_batt) begin
        thr_reg <= pwdata[7:0];
        red_reg <= pwdata[apr_pkg::RS_LSB +: apr_pkg::RS_W];
      end
    end
  end

  // Sample arrival from the link side
  wire rx_ev = rtg_sync[1] ^ rtg_sync[2];

  // Biquad engine, one multiply per cycle
  apr_pkg::apr_st_t st_reg;
  logic [3:0] sec_reg;
  logic [2:0] tap_reg;
  logic signed [71:0] acc_reg;
  logic signed [47:0] cur_reg;
  logic signed [47:0] x1_m [apr_pkg::NBQ];
  logic signed [47:0] x2_m [apr_pkg::NBQ];
  logic signed [47:0] y1_m [apr_pkg::NBQ];
  logic signed [47:0] y2_m [apr_pkg::NBQ];
  assign busy = st_reg != apr_pkg::ST_IDLE;
  wire signed [47:0] dsel = (tap_reg == 3'h0) ? cur_reg : (tap_reg == 3'h1) ? x1_m[sec_reg] :
                            (tap_reg == 3'h2) ? x2_m[sec_reg] :
                            (tap_reg == 3'h3) ? y1_m[sec_reg] : y2_m[sec_reg];
  wire signed [71:0] prod = 72'($signed(coef_mem[ci(sec_reg, tap_reg)]) * dsel);
  wire signed [71:0] acc_next = (tap_reg < 3'h3) ? acc_reg + prod : acc_reg - prod;
  wire signed [47:0] ysec = prec(sec_reg, acc_reg[apr_pkg::CFRAC +: apr_pkg::DW]);
  wire last_sec = sec_reg == 4'(apr_pkg::NBQ - 1);
  wire done = (st_reg == apr_pkg::ST_STORE) && last_sec;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < apr_pkg::NCOEF; i++)
        coef_mem[i] <= (i % apr_pkg::NTAP == 0) ? apr_pkg::COEF_ONE : 24'h0;
    end else if (wr && h_coef) begin
      coef_mem[widx] <= pwdata[23:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= apr_pkg::ST_IDLE;
      sec_reg <= 4'h0;
      tap_reg <= 3'h0;
      acc_reg <= 72'sh0;
      cur_reg <= 48'sh0;
      for (int i = 0; i < apr_pkg::NBQ; i++) begin
        x1_m[i] <= 48'sh0;
        x2_m[i] <= 48'sh0;
        y1_m[i] <= 48'sh0;
        y2_m[i] <= 48'sh0;
      end
    end else begin
      unique case (st_reg)
        apr_pkg::ST_IDLE: if (rx_ev) begin
          cur_reg <= {bundle_reg[23:0], 24'h0};
          acc_reg <= 72'sh0;
          sec_reg <= 4'h0;
          tap_reg <= 3'h0;
          st_reg <= apr_pkg::ST_MAC;
        end
        apr_pkg::ST_MAC: begin
          acc_reg <= acc_next;
          tap_reg <= tap_reg + 3'h1;
          if (tap_reg == 3'(apr_pkg::NTAP - 1)) st_reg <= apr_pkg::ST_STORE;
        end
        apr_pkg::ST_STORE: begin
          x2_m[sec_reg] <= x1_m[sec_reg];
          x1_m[sec_reg] <= cur_reg;
          y2_m[sec_reg] <= y1_m[sec_reg];
          y1_m[sec_reg] <= ysec; // R07
          cur_reg <= ysec;
          acc_reg <= 72'sh0;
          tap_reg <= 3'h0;
          sec_reg <= sec_reg + 4'h1;
          st_reg <= last_sec ? apr_pkg::ST_IDLE : apr_pkg::ST_MAC;
        end
      endcase
    end
  end

  // Gain, battery limiting, output words
  wire [7:0]  osrc_b = 8'(ctrl_reg[apr_pkg::C_OSRC +: apr_pkg::OSRC_W]);
  wire signed [31:0] g_full = ($signed(ysec[47:24]) * $signed({1'b0, gain_reg})) >>> apr_pkg::UNITY_SH;
  wire signed [31:0] g_bat = batt_low ? (g_full >>> red_reg) : g_full; // R08
  wire [23:0] res = sat(g_bat);
  wire pdm_b = ctrl_reg[apr_pkg::C_PDM];
  wire [23:0] gain_word = {gain_reg, 16'h0000};
  wire [23:0] ow_next = (pdm_b || osrc_b[2:0] == apr_pkg::OSRC_GAIN) ? gain_word :
                        (osrc_b[2:0] == apr_pkg::OSRC_CUR) ? amp_current : res; // R05 R06
  wire [23:0] mag = out_reg[23] ? -out_reg : out_reg;
  wire [7:0]  dem = mag[22:15];
  wire gain_up = gain_reg < gain_t_reg;
  wire bwe_on = ctrl_reg[apr_pkg::C_BWE];
  logic [7:0] pwm_cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_reg <= 24'h0;
      ow_reg <= 24'h0;
      aw_reg <= 24'h0;
      otg_reg <= 1'b0;
      part_reg <= 24'h0;
      gain_reg <= apr_pkg::GAIN_RST;
      bass_reg <= 8'h00;
    end else begin
      if (rx_ev) part_reg <= bundle_reg[47:24];
      if (done) begin
        out_reg <= res;
        ow_reg <= ow_next;
        aw_reg <= ctrl_reg[apr_pkg::C_AEC] ? amp_current : res;
        otg_reg <= ~otg_reg;
        if (!bwe_on) bass_reg <= 8'h00;
        if (bwe_on && gain_up && bass_reg < apr_pkg::BWE_LIMIT) bass_reg <= bass_reg + 8'h01; // R12
        else if (gain_up) gain_reg <= gain_reg + 8'h01;
        else if (gain_reg > gain_t_reg) gain_reg <= gain_reg - 8'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_cnt <= 8'h00;
      pwm_pos <= 1'b0;
      pwm_neg <= 1'b0;
      follower_mode <= 1'b1;
      boost_demand <= 8'h00;
    end else begin
      pwm_cnt <= pwm_cnt + 8'h01;
      pwm_pos <= ~out_reg[23] & (pwm_cnt < dem); // R10
      pwm_neg <= out_reg[23] & (pwm_cnt < dem); // R10
      follower_mode <= dem <= battery_level; // R11
      boost_demand <= (dem <= battery_level) ? 8'h00 : dem; // R11
    end
  end
  assign bass_extension = bass_reg;

  // ---------------- Link domain ----------------
  logic [8:0] s1_reg, s2_reg, s3_reg, flt_reg;
  logic [apr_pkg::CTRL_W-1:0] c1_reg, c2_reg, cfg_reg;
  logic [2:0] otg_sync;
  logic bck1, ws1, d1, bck2, ws2, d2, lnk_d, pdm_c, pdm_d;
  assign {pdm_d, pdm_c, lnk_d, d2, ws2, bck2, d1, ws1, bck1} = flt_reg;
  wire [8:0] agree = ~(s2_reg ^ s3_reg);
  wire pdm_m = cfg_reg[apr_pkg::C_PDM]; // R15
  wire input_stream_select = cfg_reg[apr_pkg::C_INPUT_STREAM_SELECT];
  logic wsm_reg, bckp_reg, wsp_reg, tgl_reg, dout_reg, sd_reg;
  wire sbck = pdm_m ? pdm_c : (input_stream_select ? bck2 : bck1); // R02
  wire sws = pdm_m ? wsm_reg : (input_stream_select ? ws2 : ws1); // R02
  wire sdat = input_stream_select ? d2 : d1; // R01
  wire rise = sbck & ~bckp_reg;
  wire fall = ~sbck & bckp_reg;
  wire wsch = rise & (sws != wsp_reg);
  logic [23:0] shi_reg, shl_reg, lnkl_reg, lnkr_reg, smp_reg, dspw_reg, aecw_reg, txs_reg;
  logic [5:0] dec_reg;
  logic [6:0] ones_reg;
  logic [4:0] wsc_reg;
  logic signed [25:0] sde_reg;
  wire [23:0] shi_n = {shi_reg[22:0], sdat};
  wire [23:0] shl_n = {shl_reg[22:0], lnk_d};
  wire [6:0]  ones_n = ones_reg + 7'(pdm_d);
  wire [23:0] pdm_smp = {1'b0, ones_n, 16'h0000} - apr_pkg::PDM_MID;
  wire [2:0]  osrc_l = pdm_m ? apr_pkg::OSRC_GAIN : cfg_reg[apr_pkg::C_OSRC +: apr_pkg::OSRC_W];
  wire [23:0] tx_word = (osrc_l == apr_pkg::OSRC_LEFT) ? lnkl_reg :
                        (osrc_l == apr_pkg::OSRC_RIGHT) ? lnkr_reg : dspw_reg; // R06
  wire pass_on = cfg_reg[apr_pkg::C_PASS] & ~pdm_m;
  wire pass_bit = cfg_reg[apr_pkg::C_PSRC] ? d2 : d1;
  wire signed [25:0] sd_v = sde_reg + 26'($signed(aecw_reg));

  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= 9'h000;
      s2_reg <= 9'h000;
      s3_reg <= 9'h000;
      flt_reg <= 9'h000;
      c1_reg <= apr_pkg::CTRL_RST;
      c2_reg <= apr_pkg::CTRL_RST;
      cfg_reg <= apr_pkg::CTRL_RST;
      otg_sync <= 3'h0;
    end else begin
      s1_reg <= {density_data_in, density_clock_in, stereo_link_in, serial_audio_in_second,
                 frame_select_second, serial_bit_clock_second, serial_audio_in_first,
                 frame_select_first, serial_bit_clock_first};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      flt_reg <= (agree & s2_reg) | (~agree & flt_reg);
      c1_reg <= ctrl_reg;
      c2_reg <= c1_reg;
      // Setting taken only once two samples agree, so no skewed word
      if (c1_reg == c2_reg) cfg_reg <= c1_reg; // R15
      otg_sync <= {otg_sync[1:0], otg_reg};
    end
  end

  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      bckp_reg <= 1'b0;
      wsp_reg <= 1'b0;
      shi_reg <= 24'h0;
      shl_reg <= 24'h0;
      lnkl_reg <= 24'h0;
      lnkr_reg <= 24'h0;
      smp_reg <= 24'h0;
      tgl_reg <= 1'b0;
      dec_reg <= 6'h00;
      ones_reg <= 7'h00;
      wsm_reg <= 1'b0;
      wsc_reg <= 5'h00;
    end else begin
      bckp_reg <= sbck;
      if (rise) begin
        wsp_reg <= sws;
        shi_reg <= shi_n;
        shl_reg <= shl_n; // R02
      end
      if (wsch && !wsp_reg) lnkl_reg <= shl_n; // R02
      if (wsch && wsp_reg) lnkr_reg <= shl_n;
      if (wsch && !wsp_reg && !pdm_m) begin
        smp_reg <= shi_n; // R01
        tgl_reg <= ~tgl_reg;
      end
      if (rise && pdm_m) begin
        dec_reg <= dec_reg + 6'h01;
        ones_reg <= (dec_reg == apr_pkg::PDM_DEC_LAST) ? 7'h00 : ones_n;
        wsc_reg <= wsc_reg + 5'h01;
        if (wsc_reg == apr_pkg::WSM_LAST) wsm_reg <= ~wsm_reg; // R14
        if (dec_reg == apr_pkg::PDM_DEC_LAST) begin
          smp_reg <= pdm_smp; // R04
          tgl_reg <= ~tgl_reg;
        end
      end
    end
  end

  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      dspw_reg <= 24'h0;
      aecw_reg <= 24'h0;
      txs_reg <= 24'h0;
      dout_reg <= 1'b0;
      serial_audio_out <= 1'b0;
      sde_reg <= 26'sh0;
      sd_reg <= 1'b0;
    end else begin
      if (otg_sync[1] ^ otg_sync[2]) begin
        dspw_reg <= ow_reg;
        aecw_reg <= aw_reg;
      end
      if (wsch) txs_reg <= tx_word;
      else if (fall) txs_reg <= {txs_reg[22:0], 1'b0};
      if (fall) dout_reg <= txs_reg[23];
      serial_audio_out <= pass_on ? pass_bit : dout_reg; // R03
      if (rise && pdm_m) begin
        sd_reg <= ~sd_v[25]; // R04
        sde_reg <= sd_v[25] ? sd_v + apr_pkg::SD_FS : sd_v - apr_pkg::SD_FS;
      end
    end
  end
  assign echo_reference_out = sd_reg;
  assign echo_reference_oe = pdm_m & cfg_reg[apr_pkg::C_STEREO]; // R13
  assign master_frame_select_out = wsm_reg;
  assign master_frame_select_oe = pdm_m; // R14

  // Sample bundle held with its toggle, captured across on the toggle edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rtg_sync <= 3'h0;
    else rtg_sync <= {rtg_sync[1:0], tgl_reg};
  end
  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) bundle_reg <= 48'h0;
    else if (wsch && !wsp_reg && !pdm_m) bundle_reg <= {shl_n, shi_n};
    else if (rise && pdm_m && dec_reg == apr_pkg::PDM_DEC_LAST) bundle_reg <= {lnkl_reg, pdm_smp};
  end

  AST_R03: assert property (@(posedge link_clk) disable iff (!presetn) // R03
    pass_on |=> serial_audio_out == $past(pass_bit)) else $error("pass-through broken");
  AST_R07: assert property (@(posedge pclk) disable iff (!presetn) // R07
    (st_reg == apr_pkg::ST_STORE && int'(sec_reg) >= apr_pkg::NDP) |=> cur_reg[23:0] == 24'h0)
    else $error("single precision section kept low bits");
  AST_R10: assert property (@(posedge pclk) disable iff (!presetn) // R10
    !(pwm_pos && pwm_neg)) else $error("both drives high");
  AST_R11: assert property (@(posedge pclk) disable iff (!presetn) // R11
    follower_mode |-> boost_demand == 8'h00) else $error("boost in follower mode");
  AST_R12: assert property (@(posedge pclk) disable iff (!presetn) // R12
    ($past(bwe_on) && bwe_on && gain_reg > $past(gain_reg)) |-> bass_reg == apr_pkg::BWE_LIMIT)
    else $error("level raised before bass limit");
  AST_R13: assert property (@(posedge link_clk) disable iff (!presetn) // R13
    (!pdm_m || !cfg_reg[apr_pkg::C_STEREO]) |-> !echo_reference_oe) else $error("echo pin driven");
  AST_R14: assert property (@(posedge link_clk) disable iff (!presetn) // R14
    (wsm_reg != $past(wsm_reg)) |-> $past(rise && pdm_m)) else $error("stray frame toggle");
  AST_R05: assert property (@(posedge pclk) disable iff (!presetn) // R05
    (done && pdm_b) |=> ow_reg == $past(gain_word)) else $error("serial out not gain in density mode");
endmodule // apr_audio_path
`default_nettype wire

// >>> bench/apr_host_model.sv
// Purpose: Serial host source for both input pairs and the link
// Assumes: Runs on link_clk, 4 link_clk per bit clock level
// Notes:   Frames end whole; clocks stand low while idle
`timescale 1ns/10ps
`default_nettype none
module apr_host_model (
  input  wire logic        link_clk, // Pin clock
  input  wire logic        run,      // Send frames
  input  wire logic        sel,      // 0 pair a, 1 pair b
  input  wire logic [1:0]  park,     // Idle data levels
  input  wire logic [23:0] word,     // Sent word
  output logic             bck_a,    // Bit clock a
  output logic             ws_a,     // Frame a
  output logic             d_a,      // Data a
  output logic             bck_b,    // Bit clock b
  output logic             ws_b,     // Frame b
  output logic             d_b,      // Data b
  output logic             link_d    // Link data
);
  logic [8:0] cnt = 9'h000;
  logic [5:0] bi;
  logic       bit_v;
  logic       act;
  assign act   = run | (cnt != 9'h000);
  // MSB first, LSB on the bit that carries the frame edge, right inverted
  assign bi    = cnt[8:3] - 6'h01;
  assign bit_v = (bi[4:0] >= 5'h08) ? (word[5'h1F - bi[4:0]] ^ bi[5]) : 1'b0;
  always @(posedge link_clk) begin
    cnt <= act ? cnt + 9'h001 : 9'h000;
  end
  assign bck_a  = act & ~sel & cnt[2];
  assign ws_a   = act & ~sel & cnt[8];
  assign d_a    = (act & ~sel) ? bit_v : park[0];
  assign bck_b  = act & sel & cnt[2];
  assign ws_b   = act & sel & cnt[8];
  assign d_b    = (act & sel) ? bit_v : park[1];
  assign link_d = act ? bit_v : ~park[0];
endmodule // apr_host_model
`default_nettype wire

// >>> bench/apr_audio_path_tb_top.sv
// Purpose: Self-checking bench for the audio path block
// Assumes: Register bus answers with one wait state
// Notes:   Density pins share the second pair, as on the part
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin cmp_count++; if ((s) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, s); end end
module apr_audio_path_tb_top;
  logic        pclk = 1'b0;
  logic        link_clk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, er, run, sel;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  park;
  logic [23:0] word, cur;
  logic [7:0]  batt, bst, bass;
  logic        bck_a, ws_a, d_a, bck_b, ws_b, d_b, link_d;
  logic        sout, eco, eco_oe, mfs, mfs_oe, pp, pn, fol;
  int          n_fail = 0;
  int          cmp_count = 0;
  int          tog;
  always #5 pclk = ~pclk;
  initial begin
    #1.7;
    forever #3 link_clk = ~link_clk;
  end
  apr_audio_path dut (.pclk(pclk), .presetn(presetn), .link_clk(link_clk),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_bit_clock_first(bck_a), .frame_select_first(ws_a), .serial_audio_in_first(d_a),
    .serial_bit_clock_second(bck_b), .frame_select_second(ws_b),
    .serial_audio_in_second(d_b), .stereo_link_in(link_d), .density_clock_in(bck_b),
    .density_data_in(d_b), .serial_audio_out(sout), .echo_reference_out(eco),
    .echo_reference_oe(eco_oe), .master_frame_select_out(mfs),
    .master_frame_select_oe(mfs_oe), .battery_level(batt), .amp_current(cur),
    .pwm_pos(pp), .pwm_neg(pn), .boost_demand(bst), .follower_mode(fol),
    .bass_extension(bass));
  apr_host_model host (.link_clk(link_clk), .run(run), .sel(sel), .park(park),
    .word(word), .bck_a(bck_a), .ws_a(ws_a), .d_a(d_a), .bck_b(bck_b), .ws_b(ws_b),
    .d_b(d_b), .link_d(link_d));
  always @(posedge pclk) begin
    if (presetn && pp && pn) begin
      n_fail++;
      $display("[ERR] pwm exp not both got both");
    end
  end
  always @(mfs) tog++;
  task automatic end_of_test;
    if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      n_fail++;
      end_of_test();
    end
    @(posedge pclk);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    `CHK($sformatf("reg %0h", a), e, rd & m)
  endtask
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, run, sel} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    park = 2'b01;
    word = 24'hA5C31E;
    batt = 8'hFF;
    cur = 24'h001234;
    cyc(3);
    presetn <= 1'b1;
    cyc(2);
    `CHK("follower", 1'b1, fol)
    `CHK("boost", 8'h00, bst)
    rchk(apr_pkg::A_CTRL, 32'hFFFFFFFF, 32'h0);
    rchk(apr_pkg::A_GAIN, 32'hFFFFFFFF, 32'h80);
    rchk(apr_pkg::A_BATT, 32'hFFFFFFFF, 32'h140);
    rchk(apr_pkg::A_COEF, 32'hFFFFFFFF, 32'h400000);
    rchk(12'h104, 32'hFFFFFFFF, 32'h0);
    apb(12'h1C4, 1'b1, 32'h00ABCDEF);
    rchk(12'h1C4, 32'hFFFFFFFF, 32'hABCDEF);
    rchk(12'h1C8, 32'hFFFFFFFF, 32'h0);
    `CHK("pslverr", 1'b1, er)
    apb(apr_pkg::A_PART, 1'b1, 32'hFFFFFFFF);
    rchk(apr_pkg::A_PART, 32'hFFFFFFFF, 32'h0);
    batt <= 8'h10;
    rchk(apr_pkg::A_STAT, 32'h1, 32'h1);
    batt <= 8'hFF;
    rchk(apr_pkg::A_STAT, 32'h1, 32'h0);
    for (int k = 0; k < 4; k++) begin
      park <= 2'(k);
      apb(apr_pkg::A_CTRL, 1'b1, 32'h4 | (k[0] << 3));
      cyc(20);
      `CHK("passthru", k[k[0]], sout)
      `CHK("echo_oe", 1'b0, eco_oe)
    end
    for (int s = 0; s < 2; s++) begin
      sel <= s[0];
      word <= s[0] ? 24'h3C96E1 : 24'hA5C31E;
      apb(apr_pkg::A_CTRL, 1'b1, 32'(s) << 1);
      run <= 1'b1;
      cyc(400);
      run <= 1'b0;
      cyc(700);
      rchk(apr_pkg::A_PART, 32'hFFFFFF, s[0] ? 32'h3C96E1 : 32'hA5C31E);
    end
    apb(apr_pkg::A_CTRL, 1'b1, 32'h101);
    cyc(2);
    `CHK("echo_oe", 1'b1, eco_oe)
    `CHK("frame_oe", 1'b1, mfs_oe)
    tog = 0;
    run <= 1'b1;
    cyc(700);
    run <= 1'b0;
    cyc(700);
    `CHK("frame_toggles", 6, tog)
    apb(apr_pkg::A_CTRL, 1'b1, 32'h001);
    cyc(2);
    `CHK("echo_oe", 1'b0, eco_oe)
    `CHK("frame_oe", 1'b1, mfs_oe)
    apb(apr_pkg::A_GAIN, 1'b1, 32'h84);
    apb(apr_pkg::A_CTRL, 1'b1, 32'h202);
    run <= 1'b1;
    cyc(7600);
    run <= 1'b0;
    cyc(400);
    `CHK("bass", 8'h10, bass)
    rchk(apr_pkg::A_STAT, 32'hFFFF00, 32'h108400);
    apb(apr_pkg::A_GAIN, 1'b1, 32'h80);
    apb(apr_pkg::A_CTRL, 1'b1, 32'h002);
    run <= 1'b1;
    cyc(100);
    run <= 1'b0;
    cyc(400);
    `CHK("bass", 8'h00, bass)
    rchk(apr_pkg::A_STAT, 32'hFFFF00, 32'h008300);
    end_of_test();
  end
endmodule // apr_audio_path_tb_top
`default_nettype wire
